/* src/pfgj_port_ctrl.v */
// Pin control for port F upper nibble, port G and port J behind a classic Wishbone slave
`timescale 1ns/1ns
`default_nettype none
`include "pfgj_regs.vh"

// Notes on behaviour
// - Port G has six pins, one input-only
// - Direction one is input, zero drives latch
// - Latch register readable; reads latch, not pin
// - Peripherals may force a pin output or input
// - Forced direction never stored in direction register
// - G4..G0 shared with bank-three segments
// - Sixth G pin input only, reset-select controlled
// - After reset G pins come up as inputs
// - F5 output off when segment or reference on
// - Reference output kills all F5 digital I/O
// - Analog default at reset; output unaffected
// - F7 drives latch unless segment; feeds slave-select
// - J pins drive latch when dir zero, segment off
// - Segment owning pin overrides its direction bit
// - J0..J3 seg 32..35, J4..J7 seg 39..36
// - Port data read gives pins; write sets latch
module pfgj_port_ctrl (
   input  wire        clk_i,          // System clock, 125 MHz
   input  wire        rst_i,          // Synchronous reset, active high
   input  wire [7:0]  wb_adr_i,       // Wishbone byte address
   input  wire [31:0] wb_dat_i,       // Wishbone write data
   output reg  [31:0] wb_dat_o,       // Wishbone read data
   input  wire        wb_we_i,        // Wishbone write enable
   input  wire [3:0]  wb_sel_i,       // Wishbone byte selects
   input  wire        wb_cyc_i,       // Wishbone cycle
   input  wire        wb_stb_i,       // Wishbone strobe
   output reg         wb_ack_o,       // Wishbone acknowledge
   output reg         wb_err_o,       // Wishbone error, unmapped address
   input  wire        reset_pin_select_bit_i, // Configuration: 1 = master clear
   input  wire [3:0]  pin_f_i,        // Pin levels F7..F4
   output wire [3:0]  pin_f_o,        // Pin drive values F7..F4
   output wire [3:0]  pin_f_oe_o,     // Pin drive enables F7..F4
   input  wire [5:0]  pin_g_i,        // Pin levels G5..G0
   output wire [4:0]  pin_g_o,        // Pin drive values G4..G0
   output wire [4:0]  pin_g_oe_o,     // Pin drive enables G4..G0
   input  wire [7:0]  pin_j_i,        // Pin levels J7..J0
   output wire [7:0]  pin_j_o,        // Pin drive values J7..J0
   output wire [7:0]  pin_j_oe_o,     // Pin drive enables J7..J0
   output wire [3:0]  seg_f_en_o,     // Segment drivers own F7..F4
   output wire [4:0]  seg_g_en_o,     // Segment drivers own G4..G0
   output wire [7:0]  seg_num_en_o,   // Segments 39..32 enabled
   output wire        comparator_reference_output_o, // Reference owns F5
   output wire        master_clear_n_o, // Master clear level, active low
   output wire        slave_select_o, // Slave select to serial module
   input  wire [3:0]  periph_force_out_i, // Peripheral forces F pin output
   input  wire [3:0]  periph_force_in_i,  // Peripheral forces F pin input
   input  wire [3:0]  periph_out_i,   // Peripheral drive value on F pins
   input  wire [4:0]  periph_g_force_out_i, // Peripheral forces G pin output
   input  wire [4:0]  periph_g_force_in_i,  // Peripheral forces G pin input
   input  wire [4:0]  periph_g_out_i  // Peripheral drive value on G pins
);

   // ************************************************************
   // Registers
   // ************************************************************
   reg  [3:0]  output_latch_f_ff;
   reg  [3:0]  direction_bits_f_ff;
   reg  [4:0]  output_latch_g_ff;
   reg  [4:0]  direction_bits_g_ff;
   reg  [7:0]  output_latch_j_ff;
   reg  [7:0]  direction_bits_j_ff;
   reg  [4:0]  segment_enable_bank_three_ff;
   reg  [7:0]  seg_bank_four_ff;
   reg  [3:0]  seg_bank_f_ff;
   reg  [3:0]  ctrl_ff;
   reg  [3:0]  sync1_f_ff;
   reg  [3:0]  sync2_f_ff;
   reg  [5:0]  sync1_g_ff;
   reg  [5:0]  sync2_g_ff;
   reg  [7:0]  sync1_j_ff;
   reg  [7:0]  sync2_j_ff;
   reg  [31:0] nxt_dat;
   reg         nxt_hit;

   wire req   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   wire wr    = req & wb_we_i & wb_sel_i[0];
   wire ref_en    = ctrl_ff[`PFGJ_CTRL_REF_EN_BIT];
   wire analog_f  = ctrl_ff[`PFGJ_CTRL_ANALOG_F_BIT];

   // Byte lane zero write to a given address
   function wr_hit;
      input [7:0] a;
      begin
         wr_hit = wr & (wb_adr_i == a);
      end
   endfunction

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   // Reset to the idle high level of slave select and master clear, so that
   // release of reset shows no false select or clear pulse
   always @(posedge clk_i) begin
      if (rst_i) begin
         sync1_f_ff <= 4'h8;
         sync2_f_ff <= 4'h8;
         sync1_g_ff <= 6'h20;
         sync2_g_ff <= 6'h20;
         sync1_j_ff <= 8'h00;
         sync2_j_ff <= 8'h00;
      end else begin
         sync1_f_ff <= pin_f_i;
         sync2_f_ff <= sync1_f_ff;
         sync1_g_ff <= pin_g_i;
         sync2_g_ff <= sync1_g_ff;
         sync1_j_ff <= pin_j_i;
         sync2_j_ff <= sync1_j_ff;
      end
   end

   // ************************************************************
   // Register writes
   // ************************************************************
   always @(posedge clk_i) begin
      if (rst_i) begin
         output_latch_f_ff            <= `PFGJ_RST_LATCH_F;
         direction_bits_f_ff          <= `PFGJ_RST_DIR_F;
         output_latch_g_ff            <= `PFGJ_RST_LATCH_G;
         direction_bits_g_ff          <= `PFGJ_RST_DIR_G;
         output_latch_j_ff            <= `PFGJ_RST_LATCH_J;
         direction_bits_j_ff          <= `PFGJ_RST_DIR_J;
         segment_enable_bank_three_ff <= `PFGJ_RST_SEG_G;
         seg_bank_four_ff             <= `PFGJ_RST_SEG_J;
         seg_bank_f_ff                <= `PFGJ_RST_SEG_F;
         ctrl_ff                      <= `PFGJ_RST_CTRL;
      end else begin
         // Port data and latch addresses share the latch
         if (wr_hit(`PFGJ_ADR_PIN_DATA_F) | wr_hit(`PFGJ_ADR_OUTPUT_LATCH_F))
            output_latch_f_ff <= wb_dat_i[7:4];
         if (wr_hit(`PFGJ_ADR_DIRECTION_F))
            direction_bits_f_ff <= wb_dat_i[7:4];
         if (wr_hit(`PFGJ_ADR_PIN_DATA_G) | wr_hit(`PFGJ_ADR_OUTPUT_LATCH_G))
            output_latch_g_ff <= wb_dat_i[4:0];
         if (wr_hit(`PFGJ_ADR_DIRECTION_G))
            direction_bits_g_ff <= wb_dat_i[4:0];
         if (wr_hit(`PFGJ_ADR_PIN_DATA_J) | wr_hit(`PFGJ_ADR_OUTPUT_LATCH_J))
            output_latch_j_ff <= wb_dat_i[7:0];
         if (wr_hit(`PFGJ_ADR_DIRECTION_J))
            direction_bits_j_ff <= wb_dat_i[7:0];
         if (wr_hit(`PFGJ_ADR_SEG_BANK_THREE))
            segment_enable_bank_three_ff <= wb_dat_i[4:0];
         if (wr_hit(`PFGJ_ADR_SEG_BANK_FOUR))
            seg_bank_four_ff <= wb_dat_i[7:0];
         if (wr_hit(`PFGJ_ADR_SEG_BANK_F))
            seg_bank_f_ff <= wb_dat_i[7:4];
         if (wr_hit(`PFGJ_ADR_PERIPH_CTRL))
            ctrl_ff <= wb_dat_i[3:0];
      end
   end

   // ************************************************************
   // Pin ownership
   // ************************************************************
   // Port F: segment or reference first, then peripheral, then direction
   wire [3:0] f_block;
   assign f_block = seg_bank_f_ff | ({3'h0, ref_en} << `PFGJ_F_REF_PIN_BIT);

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pf
         wire forced_out = periph_force_out_i[gi] & ~periph_force_in_i[gi];
         wire drive = ~f_block[gi] & (forced_out |
                      (~periph_force_in_i[gi] & ~direction_bits_f_ff[gi]));
         assign pin_f_oe_o[gi] = drive;
         // Analog selection leaves the driven value alone
         assign pin_f_o[gi] = forced_out ? periph_out_i[gi] : output_latch_f_ff[gi];
      end
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_pg
         wire forced_out = periph_g_force_out_i[gi] & ~periph_g_force_in_i[gi];
         wire drive = ~segment_enable_bank_three_ff[gi] & (forced_out |
                      (~periph_g_force_in_i[gi] & ~direction_bits_g_ff[gi]));
         assign pin_g_oe_o[gi] = drive;
         assign pin_g_o[gi] = forced_out ? periph_g_out_i[gi] : output_latch_g_ff[gi];
      end
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_pj
         assign pin_j_oe_o[gi] = ~seg_bank_four_ff[gi] & ~direction_bits_j_ff[gi];
         assign pin_j_o[gi] = output_latch_j_ff[gi];
      end
   endgenerate

   assign seg_f_en_o = seg_bank_f_ff;
   assign seg_g_en_o = segment_enable_bank_three_ff;
   // Segments 35..32 on J3..J0, segments 39..36 on J4..J7
   assign seg_num_en_o = {seg_bank_four_ff[4], seg_bank_four_ff[5],
                          seg_bank_four_ff[6], seg_bank_four_ff[7],
                          seg_bank_four_ff[3:0]};
   assign comparator_reference_output_o = ref_en;

   // Dual-purpose pin: master clear unless configured as port input
   wire rp5 = sync2_g_ff[`PFGJ_G_RESET_PIN_BIT];
   assign master_clear_n_o = reset_pin_select_bit_i ? rp5 : 1'b1;
   assign slave_select_o = sync2_f_ff[`PFGJ_F_SLAVE_SEL_BIT];

   // ************************************************************
   // Read-back values
   // ************************************************************
   // Analog-selected F pins read zero; reference-owned F5 gives no input
   wire [3:0] f_read_mask;
   assign f_read_mask = ~({4{analog_f}} & 4'h7) &
                        ~({3'h0, ref_en} << `PFGJ_F_REF_PIN_BIT);
   wire [3:0] f_pins = sync2_f_ff & f_read_mask;
   // Segment-owned G and J pins have no digital input; G5 reads only as port input
   wire [5:0] g_pins = {sync2_g_ff[5] & ~reset_pin_select_bit_i,
                        sync2_g_ff[4:0] & ~segment_enable_bank_three_ff};
   wire [7:0] j_pins = sync2_j_ff & ~seg_bank_four_ff;

   always @* begin
      nxt_dat = 32'h00000000;
      nxt_hit = 1'b1;
      case (wb_adr_i)
         `PFGJ_ADR_PIN_DATA_F:     nxt_dat[7:4] = f_pins;
         `PFGJ_ADR_OUTPUT_LATCH_F: nxt_dat[7:4] = output_latch_f_ff;
         `PFGJ_ADR_DIRECTION_F:    nxt_dat[7:4] = direction_bits_f_ff;
         `PFGJ_ADR_PIN_DATA_G:     nxt_dat[5:0] = g_pins;
         `PFGJ_ADR_OUTPUT_LATCH_G: nxt_dat[4:0] = output_latch_g_ff;
         `PFGJ_ADR_DIRECTION_G:    nxt_dat[4:0] = direction_bits_g_ff;
         `PFGJ_ADR_PIN_DATA_J:     nxt_dat[7:0] = j_pins;
         `PFGJ_ADR_OUTPUT_LATCH_J: nxt_dat[7:0] = output_latch_j_ff;
         `PFGJ_ADR_DIRECTION_J:    nxt_dat[7:0] = direction_bits_j_ff;
         `PFGJ_ADR_SEG_BANK_THREE: nxt_dat[4:0] = segment_enable_bank_three_ff;
         `PFGJ_ADR_SEG_BANK_FOUR:  nxt_dat[7:0] = seg_bank_four_ff;
         `PFGJ_ADR_SEG_BANK_F:     nxt_dat[7:4] = seg_bank_f_ff;
         `PFGJ_ADR_PERIPH_CTRL:    nxt_dat[3:0] = ctrl_ff;
         default:                  nxt_hit = 1'b0;
      endcase
   end

   // ************************************************************
   // Bus answer: one registered cycle, dropped the cycle after
   // ************************************************************
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req & nxt_hit;
         wb_err_o <= req & ~nxt_hit;
         if (req & ~wb_we_i)
            wb_dat_o <= nxt_dat;
      end
   end

endmodule
`default_nettype wire

/* src/pfgj_regs.vh */
// Register offsets, field positions and reset values for the port F/G/J block
`ifndef PFGJ_REGS_VH
`define PFGJ_REGS_VH

// ************************************************************
// Register byte addresses (word aligned)
// ************************************************************
`define PFGJ_ADR_PIN_DATA_F      8'h00
`define PFGJ_ADR_OUTPUT_LATCH_F  8'h04
`define PFGJ_ADR_DIRECTION_F     8'h08
`define PFGJ_ADR_PIN_DATA_G      8'h0C
`define PFGJ_ADR_OUTPUT_LATCH_G  8'h10
`define PFGJ_ADR_DIRECTION_G     8'h14
`define PFGJ_ADR_PIN_DATA_J      8'h18
`define PFGJ_ADR_OUTPUT_LATCH_J  8'h1C
`define PFGJ_ADR_DIRECTION_J     8'h20
`define PFGJ_ADR_SEG_BANK_THREE  8'h24
`define PFGJ_ADR_SEG_BANK_FOUR   8'h28
`define PFGJ_ADR_SEG_BANK_F      8'h2C
`define PFGJ_ADR_PERIPH_CTRL     8'h30

// ************************************************************
// Field positions
// ************************************************************
`define PFGJ_G_IO_W              5
`define PFGJ_G_RESET_PIN_BIT     5
`define PFGJ_F_REF_PIN_BIT       1
`define PFGJ_F_SLAVE_SEL_BIT     3
`define PFGJ_CTRL_REF_EN_BIT     0
`define PFGJ_CTRL_ANALOG_F_BIT   1
`define PFGJ_CTRL_FORCE_OUT_BIT  2
`define PFGJ_CTRL_FORCE_IN_BIT   3

// ************************************************************
// Reset values
// ************************************************************
`define PFGJ_RST_DIR_F           4'hF
`define PFGJ_RST_DIR_G           5'h1F
`define PFGJ_RST_DIR_J           8'hFF
`define PFGJ_RST_LATCH_F         4'h0
`define PFGJ_RST_LATCH_G         5'h00
`define PFGJ_RST_LATCH_J         8'h00
`define PFGJ_RST_SEG_G           5'h00
`define PFGJ_RST_SEG_J           8'h00
`define PFGJ_RST_SEG_F           4'h0
`define PFGJ_RST_CTRL            4'h2

`endif

/* sim/pfgj_board.sv */
// Board model: external levels on the F, G and J pins
`timescale 1ns/1ns
`default_nettype none
module pfgj_board (
   input  wire logic [17:0] ext_i, // Board levels J7..J0, G5..G0, F7..F4
   input  wire logic [17:0] o_i,   // Block drive values, same order
   input  wire logic [17:0] oe_i,  // Block drive enables, same order
   output wire logic [17:0] pin_o  // Level seen on each pin
);
   // Board yields only where the block drives, so a stuck enable shows as a wrong read
   assign pin_o = (oe_i & o_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

/* sim/pfgj_port_ctrl_properties.sv */
// Port-level assertions for the port F/G/J pin control block
`timescale 1ns/1ns
`default_nettype none
module pfgj_port_ctrl_properties (
   input wire logic       clk_i,        // Clock
   input wire logic       rst_i,        // Reset
   input wire logic       wb_ack_o,     // Ack
   input wire logic       wb_err_o,     // Error
   input wire logic       reset_pin_select_bit_i, // Reset pin mode
   input wire logic [3:0] pin_f_i,      // F levels
   input wire logic [3:0] pin_f_oe_o,   // F enables
   input wire logic [4:0] pin_g_oe_o,   // G enables
   input wire logic [7:0] pin_j_oe_o,   // J enables
   input wire logic [3:0] seg_f_en_o,   // F segments
   input wire logic [4:0] seg_g_en_o,   // G segments
   input wire logic [7:0] seg_num_en_o, // Segments 39..32
   input wire logic       comparator_reference_output_o, // Reference
   input wire logic       master_clear_n_o, // Master clear
   input wire logic       slave_select_o,   // Slave select
   input wire logic [3:0] periph_force_in_i // Forced inputs
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_pulse; (wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o); endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("answer held too long");
   property p_seg_g; (seg_g_en_o & pin_g_oe_o) == 5'h00; endproperty
   a_seg_g: assert property (p_seg_g) else $error("G segment pin driven");
   // Pins J4..J7 carry segments in reverse order
   property p_seg_j; (pin_j_oe_o & {seg_num_en_o[4], seg_num_en_o[5], seg_num_en_o[6],
      seg_num_en_o[7], seg_num_en_o[3:0]}) == 8'h00; endproperty
   a_seg_j: assert property (p_seg_j) else $error("J segment pin driven");
   property p_seg_f; (seg_f_en_o & pin_f_oe_o) == 4'h0; endproperty
   a_seg_f: assert property (p_seg_f) else $error("F segment pin driven");
   property p_ref; comparator_reference_output_o |-> !pin_f_oe_o[1]; endproperty
   a_ref: assert property (p_ref) else $error("reference pin driven");
   property p_force_in; (periph_force_in_i & pin_f_oe_o) == 4'h0; endproperty
   a_force_in: assert property (p_force_in) else $error("forced input driven");
   property p_mclr; !reset_pin_select_bit_i |-> master_clear_n_o; endproperty
   a_mclr: assert property (p_mclr) else $error("clear raised in input mode");
   property p_ss; $stable(pin_f_i[3]) [*4] |-> slave_select_o == pin_f_i[3]; endproperty
   a_ss: assert property (p_ss) else $error("slave select not following pin");
endmodule
bind pfgj_port_ctrl pfgj_port_ctrl_properties pfgj_port_ctrl_properties_inst (.*);
`default_nettype wire

/* sim/pfgj_port_ctrl_tb.sv */
// Self-checking bench for the port F/G/J pin control block
`timescale 1ns/1ns
`default_nettype none
`include "pfgj_regs.vh"
module pfgj_port_ctrl_tb;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, msel = 1'b0, berr;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, q;
   logic [3:0]  fo = 4'h0, fi = 4'h0;
   logic [4:0]  go = 5'h00;
   logic [17:0] ext = 18'h3FFFF;
   wire  [31:0] rdat;
   wire         ack, err, mcn, ss, cref;
   wire  [3:0]  f_o, f_oe, sf;
   wire  [4:0]  g_o, g_oe, sg;
   wire  [7:0]  j_o, j_oe, sn;
   wire  [17:0] pins;
   int          fails = 0, num_checks = 0;
   pfgj_port_ctrl pfgj_port_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_ack_o(ack), .wb_err_o(err), .reset_pin_select_bit_i(msel),
      .pin_f_i(pins[3:0]), .pin_f_o(f_o), .pin_f_oe_o(f_oe), .pin_g_i(pins[9:4]),
      .pin_g_o(g_o), .pin_g_oe_o(g_oe), .pin_j_i(pins[17:10]), .pin_j_o(j_o),
      .pin_j_oe_o(j_oe), .seg_f_en_o(sf), .seg_g_en_o(sg), .seg_num_en_o(sn),
      .comparator_reference_output_o(cref), .master_clear_n_o(mcn), .slave_select_o(ss),
      .periph_force_out_i(fo), .periph_force_in_i(fi), .periph_out_i(4'hF),
      .periph_g_force_out_i(go), .periph_g_force_in_i(5'h00), .periph_g_out_i(5'h1F));
   pfgj_board pfgj_board_inst (.ext_i(ext), .o_i({j_o, 1'b0, g_o, f_o}),
      .oe_i({j_oe, 1'b0, g_oe, f_oe}), .pin_o(pins));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Ack is read right after the edge, before that edge's own updates land
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      adr <= a;
      we <= w;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (!(ack || err) && n < 20);
      q = rdat;
      berr = err;
      cyc <= 1'b0;
      if (!(ack || err)) begin
         fails++;
         close_out();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00);
      chk($sformatf("read %h", a), {24'h0, e}, q);
   endtask
   task automatic st(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      st(3);
      chk("pin enables", {15'h0, f_oe, g_oe, j_oe}, 32'h0);
      rd(`PFGJ_ADR_DIRECTION_J, 8'hFF);
      rd(`PFGJ_ADR_PERIPH_CTRL, 8'h02);
      rd(`PFGJ_ADR_PIN_DATA_F, 8'h80);
      rd(`PFGJ_ADR_PIN_DATA_G, 8'h3F);
      wr(`PFGJ_ADR_OUTPUT_LATCH_G, 8'h15);
      ext[9:4] <= 6'h0A;
      st(3);
      rd(`PFGJ_ADR_OUTPUT_LATCH_G, 8'h15);
      rd(`PFGJ_ADR_PIN_DATA_G, 8'h0A);
      wr(`PFGJ_ADR_DIRECTION_G, 8'h00);
      st(3);
      chk("g drive", {22'h0, g_oe, g_o}, {22'h0, 5'h1F, 5'h15});
      rd(`PFGJ_ADR_PIN_DATA_G, 8'h15);
      wr(`PFGJ_ADR_SEG_BANK_THREE, 8'h03);
      st(1);
      chk("g segments", {22'h0, g_oe, sg}, {22'h0, 5'h1C, 5'h03});
      wr(`PFGJ_ADR_SEG_BANK_THREE, 8'h00);
      wr(`PFGJ_ADR_PIN_DATA_J, 8'hA5);
      rd(`PFGJ_ADR_OUTPUT_LATCH_J, 8'hA5);
      wr(`PFGJ_ADR_DIRECTION_J, 8'h00);
      st(1);
      chk("j drive", {16'h0, j_oe, j_o}, {16'h0, 8'hFF, 8'hA5});
      wr(`PFGJ_ADR_SEG_BANK_FOUR, 8'h3F);
      st(1);
      chk("j segments", {16'h0, j_oe, sn}, {16'h0, 8'hC0, 8'hCF});
      wr(`PFGJ_ADR_OUTPUT_LATCH_F, 8'hAA);
      wr(`PFGJ_ADR_DIRECTION_F, 8'h00);
      st(1);
      chk("f drive analog", {24'h0, f_oe, f_o}, {24'h0, 4'hF, 4'hA});
      wr(`PFGJ_ADR_PERIPH_CTRL, 8'h01);
      st(3);
      chk("f reference", {27'h0, cref, f_oe}, {27'h0, 1'b1, 4'hD});
      rd(`PFGJ_ADR_PIN_DATA_F, 8'h80);
      wr(`PFGJ_ADR_PERIPH_CTRL, 8'h00);
      wr(`PFGJ_ADR_SEG_BANK_F, 8'h20);
      st(1);
      chk("f segments", {24'h0, sf, f_oe}, {24'h0, 4'h2, 4'hD});
      wr(`PFGJ_ADR_DIRECTION_F, 8'hFF);
      ext[3] <= 1'b0;
      st(4);
      chk("slave select", {31'h0, ss}, 32'h0);
      wr(`PFGJ_ADR_DIRECTION_G, 8'h1F);
      fo <= 4'h1;
      go <= 5'h01;
      st(1);
      chk("force out", {29'h0, f_oe[0], f_o[0], g_oe[0]}, {29'h0, 3'h7});
      rd(`PFGJ_ADR_DIRECTION_G, 8'h1F);
      fi <= 4'h1;
      wr(`PFGJ_ADR_SEG_BANK_THREE, 8'h01);
      msel <= 1'b1;
      ext[9:4] <= 6'h2A;
      st(3);
      chk("force in", {30'h0, f_oe[0], g_oe[0]}, 32'h0);
      rd(`PFGJ_ADR_PIN_DATA_G, 8'h0A);
      ext[9] <= 1'b0;
      st(3);
      chk("master clear", {31'h0, mcn}, 32'h0);
      bus(8'h40, 1'b0, 8'h00);
      chk("unmapped error", {31'h0, berr}, 32'h1);
      close_out();
   end
endmodule
`default_nettype wire
